// ### cfag_pkg.sv
// package: types and constants for the flag and address-generation core
package cfag_pkg;

	// arithmetic unit operations and operand sizes
	typedef enum logic [2:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_ROT
	} cfag_alu_op_e;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cfag_size_e;

	// decoder directive prefix in force for the current instruction
	typedef enum logic [1:0] {DIR_NONE, DIR_BYTE_EXTEND, DIR_WORD_EXTEND} cfag_dir_e;

	// addressing modes and indirect pointer choices
	typedef enum logic [2:0] {
		AM_REG, AM_IMM, AM_INDIRECT, AM_DIRECT, AM_INDEXED, AM_PC_REL, AM_SP_REL
	} cfag_amode_e;
	typedef enum logic [2:0] {
		PTR_WORD_ACC, PTR_SECOND, PTR_IO, PTR_INDEX_X, PTR_INDEX_Y
	} cfag_ptr_e;

	// condition flags, most significant first
	typedef struct packed {
		logic s;
		logic z;
		logic h;
		logic pv;
		logic n;
		logic c;
	} cfag_flags_s;

	typedef struct packed {
		logic valid;
		cfag_alu_op_e op;
		cfag_size_e size;
		logic [31:0] a;
		logic [31:0] b;
	} cfag_alu_req_s;

	typedef struct packed {
		logic valid;
		cfag_amode_e mode;
		cfag_dir_e dir;
		cfag_ptr_e ptr;
		logic [1:0] idx;
		logic io;
		logic jump;
		logic [31:0] operand;
	} cfag_agu_req_s;

	// general pairs owned by the outside register file
	typedef struct packed {
		logic [31:0] word_acc;
		logic [31:0] second;
		logic [31:0] io_ptr;
	} cfag_pairs_s;

	typedef struct packed {
		logic valid;
		logic assigned;
		logic [1:0] line;
		logic [1:0] im;
		logic [15:0] periph;
	} cfag_irq_req_s;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_INDEX_BASE = 8'h00;
	localparam logic [7:0] REG_INDEX_BYTE_BASE = 8'h20;
	localparam logic [7:0] REG_INT = 8'h40;
	localparam logic [7:0] REG_SCRATCH = 8'h44;
	localparam logic [7:0] REG_SP = 8'h48;
	localparam logic [7:0] REG_PC = 8'h4C;
	localparam logic [7:0] REG_SELECT = 8'h50;
	localparam logic [7:0] REG_FLAGS = 8'h54;

	// select register layout and reset values
	localparam logic [7:0] SEL_WMASK = 8'h0E;
	localparam logic [7:0] SEL_RMASK = 8'h0F;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam int SEL_EXT_MODE_BIT = 0;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// interrupt mode codes and assigned-vector low bits per request line
	localparam logic [1:0] IM_VEC8 = 2'h2;
	localparam logic [1:0] IM_VEC16 = 2'h3;
	localparam logic [8:0] AV_LINE1 = 9'h004;
	localparam logic [8:0] AV_LINE2 = 9'h008;
	localparam logic [8:0] AV_LINE3 = 9'h00C;

endpackage

// ### cfag_core.sv
// flag generation, index/interrupt/scratch/stack/pc registers and address generation
// Overview of operation
// - carry set on add carry-out or subtract borrow; rotate also drives it
// - add/subtract flag set by subtracts, cleared by adds
// - arithmetic: parity/overflow flag shows signed overflow
// - logical and rotate: parity/overflow flag shows even parity
// - half carry across bit 4, 12 or 28 by operand size
// - zero flag set for an all-zero result
// - sign flag takes the result's most significant bit
// - four 32-bit index registers, primary and alternate x and y
// - high and low bytes of each index register's low half accessed alone
// - main request modes 2/3 build table address from interrupt register and peripheral
// - assigned vectors: interrupt register high half, base bits 15-9, per-line bits 8-0
// - native mode: pc increment never carries from bit 15 into 16
// - extended mode: pc increment carries through all 32 bits
// - scratch register is plain 8-bit, changed only by software writes
// - reserved select register bits always read zero
// - directives widen immediates to 24 or 32 bits
// - direct addresses 16 bits, widened to 24 or 32 by directives
// - indexed: index register plus sign-extended 8/16/24-bit displacement
// - pc-relative adds 8/16/24-bit displacement, jumps and calls only
// - stack-relative adds signed 8/16/24-bit displacement to stack pointer
// - indirect uses word pair or other pairs; index only for jumps; i/o uses i/o pair
// - extended-mode bit cleared by reset, then set until next reset
module cfag_core (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// arithmetic unit
	input wire cfag_pkg::cfag_alu_req_s i_alu,
	output logic [31:0] o_result,
	output cfag_pkg::cfag_flags_s o_flags,
	// address generation
	input wire cfag_pkg::cfag_agu_req_s i_agu,
	input wire cfag_pkg::cfag_pairs_s i_pairs,
	output logic [31:0] o_ea,
	output logic o_ea_valid,
	output logic o_ea_err,
	// program counter and mode
	input wire logic i_pc_inc,
	input wire logic i_pc_load,
	input wire logic [31:0] i_pc_value,
	input wire logic i_set_ext_mode,
	output logic [31:0] o_pc,
	output logic o_ext_mode,
	// interrupt vectors
	input wire cfag_pkg::cfag_irq_req_s i_irq,
	output logic [31:0] o_vector,
	output logic o_vec_valid
);

	logic [31:0] idx_q [4];
	logic [23:0] int_q;
	logic [7:0] scratch_q;
	logic [31:0] sp_q;
	logic [7:0] sel_q;
	logic [31:0] rd_d;
	logic [31:0] res_d;
	cfag_pkg::cfag_flags_s flg_d;
	logic [31:0] ea_d;
	logic err_d;

	// value mask for an operand size
	function automatic logic [31:0] size_mask(cfag_pkg::cfag_size_e sz);
		case (sz)
			cfag_pkg::SZ_BYTE: size_mask = 32'h0000_00FF;
			cfag_pkg::SZ_WORD: size_mask = 32'h0000_FFFF;
			default: size_mask = 32'hFFFF_FFFF;
		endcase
	endfunction

	// most significant bit for an operand size
	function automatic logic msb_of(logic [31:0] v, cfag_pkg::cfag_size_e sz);
		case (sz)
			cfag_pkg::SZ_BYTE: msb_of = v[7];
			cfag_pkg::SZ_WORD: msb_of = v[15];
			default: msb_of = v[31];
		endcase
	endfunction

	// field widening: zero-extend operands, sign-extend displacements
	function automatic logic [31:0] widen(logic [31:0] v, cfag_pkg::cfag_dir_e d, logic disp);
		logic [1:0] w;
		w = disp ? 2'(d) : 2'(d) + 2'h1;
		case (w)
			2'h0: widen = {{24{v[7]}}, v[7:0]};
			2'h1: widen = disp ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
			2'h2: widen = disp ? {{8{v[23]}}, v[23:0]} : {8'h0, v[23:0]};
			default: widen = v;
		endcase
	endfunction

	// arithmetic, logic and rotate with flag generation
	always_comb begin
		logic [31:0] m;
		logic [32:0] ax;
		logic [32:0] bx;
		logic [32:0] sum;
		logic [32:0] hx;
		logic cin;
		logic sub;
		logic sa;
		logic sb;
		m = size_mask(i_alu.size);
		ax = {1'b0, i_alu.a & m};
		bx = {1'b0, i_alu.b & m};
		cin = (i_alu.op == cfag_pkg::ALU_ADC || i_alu.op == cfag_pkg::ALU_SBC) & o_flags.c;
		sub = i_alu.op == cfag_pkg::ALU_SUB || i_alu.op == cfag_pkg::ALU_SBC;
		sum = sub ? ax - bx - {32'h0, cin} : ax + bx + {32'h0, cin};
		hx = ax ^ bx ^ sum;
		sa = msb_of(ax[31:0], i_alu.size);
		sb = msb_of(bx[31:0], i_alu.size);
		flg_d = o_flags;
		res_d = sum[31:0] & m;
		case (i_alu.op)
			cfag_pkg::ALU_ADD, cfag_pkg::ALU_ADC, cfag_pkg::ALU_SUB, cfag_pkg::ALU_SBC: begin
				case (i_alu.size)
					cfag_pkg::SZ_BYTE: flg_d.c = sum[8];
					cfag_pkg::SZ_WORD: flg_d.c = sum[16];
					default: flg_d.c = sum[32];
				endcase
				case (i_alu.size)
					cfag_pkg::SZ_BYTE: flg_d.h = hx[4];
					cfag_pkg::SZ_WORD: flg_d.h = hx[12];
					default: flg_d.h = hx[28];
				endcase
				flg_d.n = sub;
				flg_d.pv = ((sa ^ sb) == sub) && (msb_of(res_d, i_alu.size) != sa);
			end
			cfag_pkg::ALU_AND, cfag_pkg::ALU_OR, cfag_pkg::ALU_XOR: begin
				if (i_alu.op == cfag_pkg::ALU_AND) begin
					res_d = ax[31:0] & bx[31:0];
				end else if (i_alu.op == cfag_pkg::ALU_OR) begin
					res_d = ax[31:0] | bx[31:0];
				end else begin
					res_d = ax[31:0] ^ bx[31:0];
				end
				flg_d.c = 1'b0;
				flg_d.h = 1'b0;
				flg_d.n = 1'b0;
				flg_d.pv = ~^res_d;
			end
			default: begin
				res_d = ({ax[30:0], 1'b0} | {31'h0, sa}) & m;
				flg_d.c = sa;
				flg_d.h = 1'b0;
				flg_d.n = 1'b0;
				flg_d.pv = ~^res_d;
			end
		endcase
		flg_d.s = msb_of(res_d, i_alu.size);
		flg_d.z = res_d == 32'h0;
	end

	// result and flags register: all together, held when no operation
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_flags <= '0;
			o_result <= cfag_pkg::REG_RESET;
		end else if (i_alu.valid) begin
			o_flags <= flg_d;
			o_result <= res_d;
		end
	end

	// index registers: word access and single-byte access to the low half
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int k = 0; k < 4; k++) begin
				idx_q[k] <= cfag_pkg::REG_RESET;
			end
		end else if (i_wr && i_addr[7:4] == cfag_pkg::REG_INDEX_BASE[7:4]) begin
			idx_q[i_addr[3:2]] <= i_wdata;
		end else if (i_wr && i_addr[7:5] == cfag_pkg::REG_INDEX_BYTE_BASE[7:5]) begin
			if (i_addr[2]) begin
				idx_q[i_addr[4:3]][7:0] <= i_wdata[7:0];
			end else begin
				idx_q[i_addr[4:3]][15:8] <= i_wdata[7:0];
			end
		end
	end

	// interrupt, scratch, stack pointer and select registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			int_q <= cfag_pkg::REG_RESET[23:0];
			scratch_q <= cfag_pkg::REG_RESET[7:0];
			sp_q <= cfag_pkg::REG_RESET;
			sel_q <= cfag_pkg::SEL_RESET;
		end else if (i_wr) begin
			if (i_addr == cfag_pkg::REG_INT) int_q <= i_wdata[23:0];
			if (i_addr == cfag_pkg::REG_SCRATCH) scratch_q <= i_wdata[7:0];
			if (i_addr == cfag_pkg::REG_SP) sp_q <= i_wdata;
			if (i_addr == cfag_pkg::REG_SELECT) sel_q <= i_wdata[7:0] & cfag_pkg::SEL_WMASK;
		end
	end

	// extended-mode bit: set by its instruction, cleared only by reset
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ext_mode <= 1'b0;
		end else if (i_set_ext_mode) begin
			o_ext_mode <= 1'b1;
		end
	end

	// program counter: software write, then load, then increment
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_pc <= cfag_pkg::REG_RESET;
		end else if (i_wr && i_addr == cfag_pkg::REG_PC) begin
			o_pc <= i_wdata;
		end else if (i_pc_load) begin
			o_pc <= i_pc_value;
		end else if (i_pc_inc) begin
			if (o_ext_mode) begin
				o_pc <= o_pc + 32'h1;
			end else begin
				o_pc <= {o_pc[31:16], o_pc[15:0] + 16'h1};
			end
		end
	end

	// read data multiplexer; unmapped offsets read zero
	always_comb begin
		rd_d = 32'h0;
		if (i_addr[7:4] == cfag_pkg::REG_INDEX_BASE[7:4]) begin
			rd_d = idx_q[i_addr[3:2]];
		end else if (i_addr[7:5] == cfag_pkg::REG_INDEX_BYTE_BASE[7:5]) begin
			rd_d[7:0] = i_addr[2] ? idx_q[i_addr[4:3]][7:0] : idx_q[i_addr[4:3]][15:8];
		end else begin
			case (i_addr)
				cfag_pkg::REG_INT: rd_d = {8'h0, int_q};
				cfag_pkg::REG_SCRATCH: rd_d = {24'h0, scratch_q};
				cfag_pkg::REG_SP: rd_d = sp_q;
				cfag_pkg::REG_PC: rd_d = o_pc;
				cfag_pkg::REG_SELECT: begin
					rd_d[7:0] = sel_q & cfag_pkg::SEL_RMASK;
					rd_d[cfag_pkg::SEL_EXT_MODE_BIT] = o_ext_mode;
				end
				cfag_pkg::REG_FLAGS: rd_d = {26'h0, o_flags};
				default: rd_d = 32'h0;
			endcase
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= cfag_pkg::REG_RESET;
		end else begin
			o_rdata <= i_rd ? rd_d : 32'h0;
		end
	end

	// effective address by addressing mode
	always_comb begin
		ea_d = 32'h0;
		err_d = 1'b0;
		case (i_agu.mode)
			cfag_pkg::AM_REG: ea_d = i_agu.operand;
			cfag_pkg::AM_IMM: ea_d = widen(i_agu.operand, i_agu.dir, 1'b0);
			cfag_pkg::AM_DIRECT: ea_d = widen(i_agu.operand, i_agu.dir, 1'b0);
			cfag_pkg::AM_INDIRECT: begin
				case (i_agu.ptr)
					cfag_pkg::PTR_WORD_ACC: ea_d = i_pairs.word_acc;
					cfag_pkg::PTR_SECOND: ea_d = i_pairs.second;
					cfag_pkg::PTR_IO: ea_d = i_pairs.io_ptr;
					cfag_pkg::PTR_INDEX_X: ea_d = idx_q[0];
					cfag_pkg::PTR_INDEX_Y: ea_d = idx_q[2];
					default: err_d = 1'b1;
				endcase
				if (i_agu.io && i_agu.ptr != cfag_pkg::PTR_IO) err_d = 1'b1;
				if ((i_agu.ptr == cfag_pkg::PTR_INDEX_X || i_agu.ptr == cfag_pkg::PTR_INDEX_Y)
					&& (!i_agu.jump || i_agu.io)) err_d = 1'b1;
			end
			cfag_pkg::AM_INDEXED: ea_d = idx_q[i_agu.idx] + widen(i_agu.operand, i_agu.dir, 1'b1);
			cfag_pkg::AM_PC_REL: begin
				ea_d = o_pc + widen(i_agu.operand, i_agu.dir, 1'b1);
				err_d = !i_agu.jump;
			end
			cfag_pkg::AM_SP_REL: ea_d = sp_q + widen(i_agu.operand, i_agu.dir, 1'b1);
			default: err_d = 1'b1;
		endcase
	end

	// address result register; valid follows the request valid one cycle later
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ea <= cfag_pkg::REG_RESET;
			o_ea_valid <= 1'b0;
			o_ea_err <= 1'b0;
		end else begin
			o_ea_valid <= i_agu.valid;
			o_ea_err <= i_agu.valid & err_d;
			if (i_agu.valid) o_ea <= ea_d;
		end
	end

	// interrupt table address or assigned vector
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_vector <= cfag_pkg::REG_RESET;
			o_vec_valid <= 1'b0;
		end else begin
			o_vec_valid <= 1'b0;
			if (i_irq.valid && i_irq.assigned && i_irq.line != 2'h0) begin
				o_vec_valid <= 1'b1;
				case (i_irq.line)
					2'h1: o_vector <= {int_q[23:8], int_q[7:1], cfag_pkg::AV_LINE1};
					2'h2: o_vector <= {int_q[23:8], int_q[7:1], cfag_pkg::AV_LINE2};
					default: o_vector <= {int_q[23:8], int_q[7:1], cfag_pkg::AV_LINE3};
				endcase
			end else if (i_irq.valid && !i_irq.assigned && i_irq.im == cfag_pkg::IM_VEC8) begin
				o_vec_valid <= 1'b1;
				o_vector <= {int_q, i_irq.periph[7:0]};
			end else if (i_irq.valid && !i_irq.assigned && i_irq.im == cfag_pkg::IM_VEC16) begin
				o_vec_valid <= 1'b1;
				o_vector <= {int_q[23:8], i_irq.periph};
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_pc_inc_only;
		i_pc_inc && !i_pc_load && !(i_wr && i_addr == cfag_pkg::REG_PC);
	endsequence

	a_zero_flag: assert property (
		i_alu.valid |=> o_flags.z == (o_result == 32'h0))
		else $error("zero flag disagrees with result");
	a_add_sub_flag: assert property (
		i_alu.valid && i_alu.op inside {cfag_pkg::ALU_ADD, cfag_pkg::ALU_SUB}
		|=> o_flags.n == ($past(i_alu.op) == cfag_pkg::ALU_SUB))
		else $error("add/subtract flag wrong");
	a_byte_sign: assert property (
		i_alu.valid && i_alu.size == cfag_pkg::SZ_BYTE |=> o_flags.s == o_result[7])
		else $error("sign flag wrong");
	a_byte_carry: assert property (
		i_alu.valid && i_alu.op == cfag_pkg::ALU_ADD && i_alu.size == cfag_pkg::SZ_BYTE
		|=> o_flags.c == (({1'b0, $past(i_alu.a[7:0])} + {1'b0, $past(i_alu.b[7:0])}) > 9'h0FF))
		else $error("byte carry wrong");
	a_flags_hold: assert property (
		!i_alu.valid |=> $stable(o_flags))
		else $error("flags moved without an operation");
	a_ext_mode_sticky: assert property (
		o_ext_mode |=> o_ext_mode [*8])
		else $error("extended-mode bit cleared without reset");
	a_native_wrap: assert property (
		s_pc_inc_only ##0 !o_ext_mode |=> o_pc[31:16] == $past(o_pc[31:16])
		&& o_pc[15:0] == $past(o_pc[15:0]) + 16'h1)
		else $error("native pc carried into upper half");
	a_ext_carry: assert property (
		s_pc_inc_only ##0 o_ext_mode |=> o_pc == $past(o_pc) + 32'h1)
		else $error("extended pc increment wrong");
	a_scratch_hold: assert property (
		!(i_wr && i_addr == cfag_pkg::REG_SCRATCH) |=> $stable(scratch_q))
		else $error("scratch changed without a write");
	a_select_zero: assert property (
		i_rd && i_addr == cfag_pkg::REG_SELECT |=> o_rdata[31:4] == 28'h0)
		else $error("reserved select bits read nonzero");
	a_pcrel_jump: assert property (
		i_agu.valid && i_agu.mode == cfag_pkg::AM_PC_REL && !i_agu.jump |=> o_ea_err)
		else $error("pc-relative accepted outside jump");
	a_direct_width: assert property (
		i_agu.valid && i_agu.mode == cfag_pkg::AM_DIRECT && i_agu.dir == cfag_pkg::DIR_NONE
		|=> o_ea[31:16] == 16'h0 && o_ea_valid)
		else $error("direct address wider than 16 bits");

endmodule // cfag_core

// ### cfag_core_test.sv
// self-checking bench for the flag and address-generation core
module cfag_core_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata, o_result, o_ea, o_pc, o_vector;
	cfag_pkg::cfag_alu_req_s i_alu = '0;
	cfag_pkg::cfag_flags_s o_flags;
	cfag_pkg::cfag_agu_req_s i_agu = '0;
	cfag_pkg::cfag_pairs_s i_pairs = '{32'hA000_0000, 32'hB000_0000, 32'hC000_0000};
	cfag_pkg::cfag_irq_req_s i_irq = '0;
	logic o_ea_valid, o_ea_err, o_ext_mode, o_vec_valid;
	logic i_pc_inc = 1'b0;
	logic i_pc_load = 1'b0;
	logic [31:0] i_pc_value = 32'h0;
	logic i_set_ext_mode = 1'b0;
	int failures = 0;
	int checked = 0;

	cfag_core uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_alu(i_alu), .o_result(o_result),
		.o_flags(o_flags), .i_agu(i_agu), .i_pairs(i_pairs), .o_ea(o_ea),
		.o_ea_valid(o_ea_valid), .o_ea_err(o_ea_err), .i_pc_inc(i_pc_inc),
		.i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_set_ext_mode(i_set_ext_mode),
		.o_pc(o_pc), .o_ext_mode(o_ext_mode), .i_irq(i_irq), .o_vector(o_vector),
		.o_vec_valid(o_vec_valid));

	// 100 MHz clock
	always #5 i_clk = ~i_clk;

	// closing report, reached from the main sequence or the watchdog
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// compare one value, reporting a mismatch at once
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// bus write: one cycle with the strobe high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// bus read: data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", exp, o_rdata);
	endtask

	// arithmetic request, result and flags one cycle later
	task automatic alu(input cfag_pkg::cfag_alu_op_e op, input cfag_pkg::cfag_size_e sz,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] res, input logic [5:0] f);
		@(posedge i_clk);
		i_alu <= '{valid: 1'b1, op: op, size: sz, a: a, b: b};
		@(posedge i_clk);
		i_alu.valid <= 1'b0;
		#1 chk("result", res, o_result);
		chk("flags", {26'h0, f}, {26'h0, o_flags});
	endtask

	// address request, effective address checked unless refused
	task automatic agu(input cfag_pkg::cfag_amode_e m, input cfag_pkg::cfag_dir_e d,
		input cfag_pkg::cfag_ptr_e p, input logic io, input logic j, input logic [31:0] opd,
		input logic [31:0] ea, input logic err);
		@(posedge i_clk);
		i_agu <= '{valid: 1'b1, mode: m, dir: d, ptr: p, idx: 2'h0, io: io, jump: j,
			operand: opd};
		@(posedge i_clk);
		i_agu.valid <= 1'b0;
		#1 chk("ea_valid", 32'h1, {31'h0, o_ea_valid});
		chk("ea_err", {31'h0, err}, {31'h0, o_ea_err});
		if (!err) chk("ea", ea, o_ea);
	endtask

	// interrupt vector request
	task automatic vec(input logic as, input logic [1:0] ln, input logic [1:0] im,
		input logic [15:0] pr, input logic [31:0] exp, input logic vld);
		@(posedge i_clk);
		i_irq <= '{valid: 1'b1, assigned: as, line: ln, im: im, periph: pr};
		@(posedge i_clk);
		i_irq.valid <= 1'b0;
		#1 chk("vec_valid", {31'h0, vld}, {31'h0, o_vec_valid});
		if (vld) chk("vector", exp, o_vector);
	endtask

	// program counter strobes: load, increment, set extended mode
	task automatic pc_op(input logic ld, input logic inc, input logic em, input logic [31:0] v);
		@(posedge i_clk);
		i_pc_load <= ld;
		i_pc_inc <= inc;
		i_set_ext_mode <= em;
		i_pc_value <= v;
		@(posedge i_clk);
		i_pc_load <= 1'b0;
		i_pc_inc <= 1'b0;
		i_set_ext_mode <= 1'b0;
		#1;
	endtask

	task automatic do_reset();
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		#1 chk("ext_mode", 32'h0, {31'h0, o_ext_mode});
		chk("pc", 32'h0, o_pc);
	endtask

	task automatic test_registers();
		rd(cfag_pkg::REG_FLAGS, 32'h0);
		wr(cfag_pkg::REG_INDEX_BASE + 8'h04, 32'h1122_3344);
		wr(cfag_pkg::REG_INDEX_BYTE_BASE + 8'h08, 32'h0000_00AA);
		wr(cfag_pkg::REG_INDEX_BYTE_BASE + 8'h0C, 32'h0000_00BB);
		rd(cfag_pkg::REG_INDEX_BASE + 8'h04, 32'h1122_AABB);
		rd(cfag_pkg::REG_INDEX_BYTE_BASE + 8'h08, 32'h0000_00AA);
		wr(cfag_pkg::REG_SCRATCH, 32'hFFFF_FF5A);
		repeat (20) @(posedge i_clk);
		rd(cfag_pkg::REG_SCRATCH, 32'h0000_005A);
		wr(cfag_pkg::REG_SELECT, 32'hFFFF_FFFF);
		rd(cfag_pkg::REG_SELECT, 32'h0000_000E);
		wr(8'h60, 32'h1234_5678);
		rd(8'h60, 32'h0);
	endtask

	task automatic test_flags();
		alu(cfag_pkg::ALU_ADD, cfag_pkg::SZ_BYTE, 32'hFF, 32'h01, 32'h00, 6'h19);
		alu(cfag_pkg::ALU_SUB, cfag_pkg::SZ_BYTE, 32'h00, 32'h01, 32'hFF, 6'h2B);
		rd(cfag_pkg::REG_FLAGS, 32'h0000_002B);
		alu(cfag_pkg::ALU_ADD, cfag_pkg::SZ_BYTE, 32'h7F, 32'h01, 32'h80, 6'h2C);
		alu(cfag_pkg::ALU_ADD, cfag_pkg::SZ_WORD, 32'h0FFF, 32'h1, 32'h1000, 6'h08);
		alu(cfag_pkg::ALU_ADD, cfag_pkg::SZ_WORD, 32'h000F, 32'h1, 32'h0010, 6'h00);
		alu(cfag_pkg::ALU_ADD, cfag_pkg::SZ_LONG, 32'h0FFF_FFFF, 32'h1, 32'h1000_0000, 6'h08);
		alu(cfag_pkg::ALU_AND, cfag_pkg::SZ_BYTE, 32'h03, 32'hFF, 32'h03, 6'h04);
		alu(cfag_pkg::ALU_OR, cfag_pkg::SZ_BYTE, 32'h80, 32'h00, 32'h80, 6'h20);
		alu(cfag_pkg::ALU_XOR, cfag_pkg::SZ_BYTE, 32'h01, 32'h00, 32'h01, 6'h00);
		alu(cfag_pkg::ALU_ROT, cfag_pkg::SZ_BYTE, 32'h81, 32'h00, 32'h03, 6'h05);
		alu(cfag_pkg::ALU_ADC, cfag_pkg::SZ_BYTE, 32'h01, 32'h01, 32'h03, 6'h00);
		alu(cfag_pkg::ALU_SBC, cfag_pkg::SZ_BYTE, 32'h03, 32'h04, 32'hFF, 6'h2B);
	endtask

	task automatic test_pc();
		pc_op(1'b1, 1'b0, 1'b0, 32'h0001_FFFF);
		pc_op(1'b0, 1'b1, 1'b0, 32'h0);
		chk("pc", 32'h0001_0000, o_pc);
		pc_op(1'b0, 1'b0, 1'b1, 32'h0);
		chk("ext_mode", 32'h1, {31'h0, o_ext_mode});
		pc_op(1'b1, 1'b0, 1'b0, 32'h0001_FFFF);
		pc_op(1'b0, 1'b1, 1'b0, 32'h0);
		chk("pc", 32'h0002_0000, o_pc);
		wr(cfag_pkg::REG_SELECT, 32'h0);
		rd(cfag_pkg::REG_SELECT, 32'h0000_0001);
	endtask

	task automatic test_agu();
		wr(cfag_pkg::REG_INDEX_BASE, 32'h0000_1000);
		wr(cfag_pkg::REG_SP, 32'h0000_0100);
		agu(cfag_pkg::AM_INDEXED, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'hFE, 32'h0000_0FFE, 0);
		agu(cfag_pkg::AM_INDEXED, cfag_pkg::DIR_BYTE_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h8000, 32'hFFFF_9000, 0);
		agu(cfag_pkg::AM_DIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h0000_5678, 0);
		agu(cfag_pkg::AM_DIRECT, cfag_pkg::DIR_BYTE_EXTEND, cfag_pkg::PTR_WORD_ACC, 1, 0,
			32'h1234_5678, 32'h0034_5678, 0);
		agu(cfag_pkg::AM_DIRECT, cfag_pkg::DIR_WORD_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h1234_5678, 0);
		agu(cfag_pkg::AM_IMM, cfag_pkg::DIR_BYTE_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h0034_5678, 0);
		agu(cfag_pkg::AM_IMM, cfag_pkg::DIR_WORD_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h1234_5678, 0);
		agu(cfag_pkg::AM_IMM, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h0000_5678, 0);
		agu(cfag_pkg::AM_REG, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h1234_5678, 32'h1234_5678, 0);
		agu(cfag_pkg::AM_SP_REL, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'hFF, 32'h0000_00FF, 0);
		agu(cfag_pkg::AM_SP_REL, cfag_pkg::DIR_WORD_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h0080_0000, 32'hFF80_0100, 0);
		agu(cfag_pkg::AM_PC_REL, cfag_pkg::DIR_BYTE_EXTEND, cfag_pkg::PTR_WORD_ACC, 0, 1,
			32'hFFFF, 32'h0001_FFFF, 0);
		agu(cfag_pkg::AM_PC_REL, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h10, 32'h0, 1);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 0, 0,
			32'h0, 32'hA000_0000, 0);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_SECOND, 0, 0,
			32'h0, 32'hB000_0000, 0);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_IO, 1, 0,
			32'h0, 32'hC000_0000, 0);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_WORD_ACC, 1, 0,
			32'h0, 32'h0, 1);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_INDEX_X, 0, 1,
			32'h0, 32'h0000_1000, 0);
		agu(cfag_pkg::AM_INDIRECT, cfag_pkg::DIR_NONE, cfag_pkg::PTR_INDEX_X, 0, 0,
			32'h0, 32'h0, 1);
	endtask

	task automatic test_vectors();
		wr(cfag_pkg::REG_INT, 32'h00AB_CDEF);
		vec(1'b0, 2'h0, cfag_pkg::IM_VEC8, 16'h3412, 32'hABCD_EF12, 1'b1);
		vec(1'b0, 2'h0, cfag_pkg::IM_VEC16, 16'h3456, 32'hABCD_3456, 1'b1);
		vec(1'b0, 2'h0, 2'h0, 16'h3456, 32'h0, 1'b0);
		vec(1'b1, 2'h1, 2'h0, 16'h0, {16'hABCD, 7'h77, cfag_pkg::AV_LINE1}, 1'b1);
		vec(1'b1, 2'h2, 2'h0, 16'h0, {16'hABCD, 7'h77, cfag_pkg::AV_LINE2}, 1'b1);
		vec(1'b1, 2'h3, 2'h0, 16'h0, {16'hABCD, 7'h77, cfag_pkg::AV_LINE3}, 1'b1);
	endtask

	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		report_and_stop();
	end

	// main sequence
	initial begin
		do_reset();
		test_registers();
		test_flags();
		test_pc();
		test_agu();
		test_vectors();
		do_reset();
		rd(cfag_pkg::REG_SELECT, 32'h0);
		rd(cfag_pkg::REG_FLAGS, 32'h0);
		report_and_stop();
	end
endmodule // cfag_core_test
